// >>> far_side_model.sv
`timescale 1ns/1ns
`default_nettype none
module far_side_model import pin_mux_pkg::*; (
  input  wire logic [NUM_PINS-1:0] pin_o,
  input  wire logic [NUM_PINS-1:0] pin_oe,
  input  wire logic                drive_en,
  input  wire logic [7:0]          drive_val,
  output logic      [NUM_PINS-1:0] pin_i
);
  // ===========================================================================
  // Wire levels
  // Every line carries an external pull-up, so a released pin reads high unless drive_en puts drive_val on a data pin,
  // and never keeps the last value that was driven onto it.
  always_comb begin
    for (int k = 0; k < NUM_PINS; k++) begin
      if (pin_oe[k]) begin
        pin_i[k] = pin_o[k];
      end else if (drive_en && k >= PIN_DATA0 && k < PIN_DATA0 + 8) begin
        pin_i[k] = drive_val[k - PIN_DATA0];
      end else begin
        pin_i[k] = 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> floppy_route.sv
`timescale 1ns/1ns
`default_nettype none
module floppy_route import pin_mux_pkg::*; (
  mux_ctrl_if.router ctl
);
  logic pair0_on;
  logic pair1_on;
  // Drive outputs are open drain: enable only while the signal is asserted low.
  always_comb begin
    pair0_on  = ~ctl.single_mode | ctl.drive_swap;
    pair1_on  = ~ctl.single_mode | ~ctl.drive_swap;
    ctl.fl_oe = '0;
    ctl.fl_oe[PIN_STROBE]    = pair0_on & ~ctl.fdc_out[FO_SEL0];
    ctl.fl_oe[PIN_DATA0+6]   = pair0_on & ~ctl.fdc_out[FO_MOTOR0];
    ctl.fl_oe[PIN_ACK]       = pair1_on & ~ctl.fdc_out[FO_SEL1];
    ctl.fl_oe[PIN_BUSY]      = pair1_on & ~ctl.fdc_out[FO_MOTOR1];
    ctl.fl_oe[PIN_PAPER_END] = ~ctl.fdc_out[FO_WRITE_DATA];
    ctl.fl_oe[PIN_SELECTED]  = ~ctl.fdc_out[FO_WRITE_GATE];
    ctl.fl_oe[PIN_AUTO_FEED] = ~ctl.fdc_out[FO_DENSITY];
    ctl.fl_oe[PIN_ERROR]     = ~ctl.fdc_out[FO_HEAD];
    ctl.fl_oe[PIN_INIT]      = ~ctl.fdc_out[FO_DIR];
    ctl.fl_oe[PIN_SELECT_IN] = ~ctl.fdc_out[FO_STEP];
    ctl.fdc_in = {ctl.pin_s[PIN_DATA0+7], ctl.pin_s[PIN_DATA0+5:PIN_DATA0]};
  end
endmodule
`default_nettype wire

// >>> mux_ctrl_if.sv
`timescale 1ns/1ns
`default_nettype none
interface mux_ctrl_if;
  import pin_mux_pkg::*;
  logic                host_sel;
  logic [1:0]          mode_bits;
  logic                fdc_active;
  logic                fdc_pd;
  logic                pp_active;
  logic                pp_pd;
  logic                port_en;
  logic                power_good;
  logic                drive_swap;
  owner_t              owner;
  logic                live;
  logic                single_mode;
  logic [FO_COUNT-1:0] fdc_out;
  logic [FI_COUNT-1:0] fdc_in;
  logic [NUM_PINS-1:0] pin_s;
  logic [NUM_PINS-1:0] fl_oe;
  modport top (output host_sel, mode_bits, fdc_active, fdc_pd, pp_active, pp_pd, port_en,
               power_good, drive_swap, fdc_out, pin_s,
               input owner, live, single_mode, fdc_in, fl_oe);
  modport decode (input host_sel, mode_bits, fdc_active, fdc_pd, pp_active, pp_pd, port_en,
                  power_good, output owner, live, single_mode);
  modport router (input single_mode, drive_swap, fdc_out, pin_s, output fdc_in, fl_oe);
endinterface
`default_nettype wire

// >>> owner_decode.sv
`timescale 1ns/1ns
`default_nettype none
module owner_decode import pin_mux_pkg::*; #(
  parameter logic [1:0] SINGLE_PATTERN = 2'h1
) (
  mux_ctrl_if.decode ctl
);
  always_comb begin
    ctl.single_mode = (ctl.mode_bits == SINGLE_PATTERN);
    if (!ctl.host_sel) begin
      ctl.owner = OWN_MCU;
      ctl.live  = ctl.power_good;
    end else if (ctl.mode_bits[0] ^ ctl.mode_bits[1]) begin
      ctl.owner = OWN_FLOPPY;
      // The port-enable bit is deliberately left out here.
      ctl.live  = ctl.fdc_active & ~ctl.fdc_pd;
    end else begin
      ctl.owner = OWN_HOST;
      ctl.live  = ctl.pp_active & ~ctl.pp_pd & ctl.port_en;
    end
  end
endmodule
`default_nettype wire

// >>> parallel_port_pin_owner_mux.sv
`timescale 1ns/1ns
`default_nettype none
module parallel_port_pin_owner_mux import pin_mux_pkg::*; #(
  parameter logic [1:0] SINGLE_PATTERN = 2'h1
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                power_good_pin,
  input  wire logic [NUM_PINS-1:0] pin_i,
  output logic      [NUM_PINS-1:0] pin_o,
  output logic      [NUM_PINS-1:0] pin_oe,
  output logic      [NUM_PINS-1:0] pin_sampled,
  input  wire logic [NUM_PINS-1:0] mcu_o,
  input  wire logic                mcu_data_out_en,
  input  wire logic [NUM_PINS-1:0] lp_o,
  input  wire logic [NUM_PINS-1:0] lp_oe,
  input  wire logic                lp_data_wr_stb,
  input  wire logic [7:0]          lp_data_wr,
  input  wire logic [7:0]          lp_data_rd_in,
  input  wire logic [7:0]          lp_ctrl_rd_in,
  input  wire logic [7:0]          lp_status_rd_in,
  output logic      [7:0]          lp_data_rd,
  output logic      [7:0]          lp_ctrl_rd,
  output logic      [7:0]          lp_status_rd,
  input  wire logic [FO_COUNT-1:0] fdc_drive_out,
  output logic      [FI_COUNT-1:0] fdc_drive_in
);
  // ===========================================================================
  // State
  typedef struct packed {
    logic [NUM_PINS-1:0] pin_m;
    logic [NUM_PINS-1:0] pin_s;
    logic                pg_m;
    logic                pg_s;
    logic [7:0]          dev_mode;
    logic [7:0]          owner_ctrl;
    logic [7:0]          floppy_mode;
    logic [7:0]          disable_r;
    logic [31:0]         rdata;
    logic                err;
    logic [7:0]          data_shadow;
    logic [7:0]          lp_data;
    logic [7:0]          lp_ctrl;
    logic [7:0]          lp_status;
    logic [NUM_PINS-1:0] pin_o;
    logic [NUM_PINS-1:0] pin_oe;
  } state_t;

  state_t state_q;
  state_t state_d;
  logic   setup_phase;
  logic   access_phase;

  mux_ctrl_if ctl ();

  // ===========================================================================
  // Ownership decode and floppy routing
  owner_decode #(
    .SINGLE_PATTERN (SINGLE_PATTERN)
  ) u_decode (
    .ctl (ctl.decode)
  );

  floppy_route u_route (
    .ctl (ctl.router)
  );

  assign ctl.host_sel   = state_q.owner_ctrl[OWN_HOST_SEL];
  assign ctl.mode_bits  = state_q.dev_mode[MODE_LO+1:MODE_LO];
  assign ctl.fdc_active = state_q.owner_ctrl[OWN_FDC_ACT];
  assign ctl.fdc_pd     = state_q.owner_ctrl[OWN_FDC_PD];
  assign ctl.pp_active  = state_q.owner_ctrl[OWN_PP_ACT];
  assign ctl.pp_pd      = state_q.owner_ctrl[OWN_PP_PD];
  assign ctl.port_en    = state_q.disable_r[DIS_PORT_EN];
  assign ctl.power_good = state_q.pg_s;
  assign ctl.drive_swap = state_q.floppy_mode[FM_DRIVE_SWAP];
  assign ctl.fdc_out    = fdc_drive_out;
  assign ctl.pin_s      = state_q.pin_s;

  // ===========================================================================
  // Register access helpers
  function automatic logic addr_hit(input logic [11:0] a);
    if (a == ADDR_DEVICE_MODE) begin
      return 1'b1;
    end else if (a == ADDR_OWNER_CTRL || a == ADDR_FLOPPY_MODE) begin
      return 1'b1;
    end else if (a == ADDR_DISABLE || a == ADDR_STATUS) begin
      return 1'b1;
    end else begin
      return 1'b0;
    end
  endfunction

  function automatic logic [31:0] read_value(input logic [11:0] a, input state_t s,
                                             input logic [5:0] st);
    if (a == ADDR_DEVICE_MODE) begin
      return {24'h000000, s.dev_mode};
    end else if (a == ADDR_OWNER_CTRL) begin
      return {24'h000000, s.owner_ctrl};
    end else if (a == ADDR_FLOPPY_MODE) begin
      return {24'h000000, s.floppy_mode};
    end else if (a == ADDR_DISABLE) begin
      return {24'h000000, s.disable_r};
    end else if (a == ADDR_STATUS) begin
      return {26'h0, st};
    end else begin
      return 32'h00000000;
    end
  endfunction

  assign setup_phase  = psel & ~penable;
  assign access_phase = psel & penable;

  // ===========================================================================
  // Next state
  always_comb begin
    state_d = state_q;

    // Pins and power-good come from outside; two flops before any use.
    state_d.pin_m = pin_i;
    state_d.pin_s = state_q.pin_m;
    state_d.pg_m  = power_good_pin;
    state_d.pg_s  = state_q.pg_m;

    // Read data and error are captured in the setup cycle, so the access
    // cycle can complete at once with both already in flops.
    if (setup_phase) begin
      state_d.err   = ~addr_hit(paddr);
      state_d.rdata = read_value(paddr, state_q,
                                 {ctl.single_mode, state_q.pg_s, ctl.live, ctl.owner});
    end

    if (access_phase && pwrite) begin
      if (paddr == ADDR_DEVICE_MODE) begin
        state_d.dev_mode = pwdata[7:0];
      end else if (paddr == ADDR_OWNER_CTRL) begin
        state_d.owner_ctrl = pwdata[7:0];
      end else if (paddr == ADDR_FLOPPY_MODE) begin
        state_d.floppy_mode = pwdata[7:0];
      end else if (paddr == ADDR_DISABLE) begin
        state_d.disable_r = pwdata[7:0];
      end
    end

    // The shadow keeps tracking host writes even while the host owns the pins,
    // so a later loss of ownership reads back the true last value.
    if (lp_data_wr_stb) begin
      state_d.data_shadow = lp_data_wr;
    end

    if (ctl.owner == OWN_HOST) begin
      state_d.lp_data   = lp_data_rd_in;
      state_d.lp_ctrl   = lp_ctrl_rd_in;
      state_d.lp_status = lp_status_rd_in;
    end else begin
      state_d.lp_data   = lp_data_wr_stb ? lp_data_wr : state_q.data_shadow;
      state_d.lp_ctrl   = (lp_ctrl_rd_in & ~CTRL_DISC_MASK) | CTRL_DISC_VAL;
      state_d.lp_status = (lp_status_rd_in & ~STAT_DISC_MASK) | STAT_DISC_VAL;
    end

    // A dead owner floats every pin rather than leaving stale drive.
    case (ctl.owner)
      OWN_MCU: begin
        state_d.pin_o  = mcu_o;
        state_d.pin_oe = ctl.live ? (MCU_OUT_MASK | (mcu_data_out_en ? MCU_DATA_MASK
                                                                      : '0)) : '0;
      end
      OWN_FLOPPY: begin
        state_d.pin_o  = '0;
        state_d.pin_oe = ctl.live ? ctl.fl_oe : '0;
      end
      OWN_HOST: begin
        state_d.pin_o  = lp_o;
        state_d.pin_oe = ctl.live ? lp_oe : '0;
      end
      default: begin
        state_d.pin_o  = '0;
        state_d.pin_oe = '0;
      end
    endcase
  end

  // ===========================================================================
  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q             <= '0;
      state_q.dev_mode    <= DEVICE_MODE_RST;
      state_q.owner_ctrl  <= OWNER_CTRL_RST;
      state_q.floppy_mode <= FLOPPY_MODE_RST;
      state_q.disable_r   <= DISABLE_RST;
    end else begin
      state_q <= state_d;
    end
  end

  // ===========================================================================
  // Outputs
  assign prdata       = state_q.rdata;
  assign pready       = 1'b1;
  assign pslverr      = state_q.err;
  assign pin_o        = state_q.pin_o;
  assign pin_oe       = state_q.pin_oe;
  assign pin_sampled  = state_q.pin_s;
  assign lp_data_rd   = state_q.lp_data;
  assign lp_ctrl_rd   = state_q.lp_ctrl;
  assign lp_status_rd = state_q.lp_status;
  assign fdc_drive_in = ctl.fdc_in;

  // ===========================================================================
  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_mcu_owner_sel: assert property (
    !state_q.owner_ctrl[OWN_HOST_SEL] |-> ctl.owner == OWN_MCU)
    else $error("host select low did not give the pins to the microcontroller");

  chk_floppy_owner_mode: assert property (
    (state_q.owner_ctrl[OWN_HOST_SEL] && ^state_q.dev_mode[MODE_LO+1:MODE_LO])
    |-> ctl.owner == OWN_FLOPPY)
    else $error("mixed mode bits did not select floppy ownership");

  chk_host_owner_mode: assert property (
    (state_q.owner_ctrl[OWN_HOST_SEL] && !(^state_q.dev_mode[MODE_LO+1:MODE_LO]))
    |-> ctl.owner == OWN_HOST)
    else $error("equal mode bits did not select legacy ownership");

  chk_host_pd_float: assert property (
    (ctl.owner == OWN_HOST && state_q.owner_ctrl[OWN_PP_PD]) |=> pin_oe == '0)
    else $error("powered-down legacy port still drives pins");

  chk_floppy_pd_float: assert property (
    (ctl.owner == OWN_FLOPPY && state_q.owner_ctrl[OWN_FDC_PD]) |=> pin_oe == '0)
    else $error("powered-down floppy controller still drives pins");

  chk_mcu_drive_pg: assert property (
    (ctl.owner == OWN_MCU) |=>
    (($past(state_q.pg_s) ? (pin_oe & MCU_OUT_MASK) == MCU_OUT_MASK : pin_oe == '0)))
    else $error("microcontroller drive does not follow power-good");

  chk_pg_sync_delay: assert property (
    $rose(power_good_pin) ##1 power_good_pin[*2] |-> state_q.pg_s)
    else $error("power-good not seen after two flops");

  chk_data_shadow_read: assert property (
    (lp_data_wr_stb && ctl.owner != OWN_HOST) |=> lp_data_rd == $past(lp_data_wr))
    else $error("legacy data read did not return the last write");

  chk_ctrl_disconnect: assert property (
    ctl.owner != OWN_HOST |=> (lp_ctrl_rd & CTRL_DISC_MASK) == CTRL_DISC_VAL)
    else $error("control read not shown as cable disconnected");

  chk_status_disconnect: assert property (
    ctl.owner != OWN_HOST |=> (lp_status_rd & STAT_DISC_MASK) == STAT_DISC_VAL)
    else $error("status read not shown as cable disconnected");

  chk_port_en_ignored: assert property (
    (ctl.owner == OWN_FLOPPY && state_q.owner_ctrl[OWN_FDC_ACT]
     && !state_q.owner_ctrl[OWN_FDC_PD]) |-> ctl.live)
    else $error("port-enable bit affected floppy ownership");

  chk_single_pair_off: assert property (
    (ctl.owner == OWN_FLOPPY && ctl.single_mode && !state_q.floppy_mode[FM_DRIVE_SWAP])
    |=> !pin_oe[PIN_STROBE] && !pin_oe[PIN_DATA0+6])
    else $error("inactive drive pair driven in single-drive mode");

  chk_step_route: assert property (
    (ctl.owner == OWN_FLOPPY && ctl.live && !fdc_drive_out[FO_STEP])
    |=> pin_oe[PIN_SELECT_IN] && !pin_o[PIN_SELECT_IN])
    else $error("step pulse not routed to select-in pin");

  chk_swap_pair_off: assert property (
    (ctl.owner == OWN_FLOPPY && ctl.single_mode && state_q.floppy_mode[FM_DRIVE_SWAP])
    |=> !pin_oe[PIN_ACK] && !pin_oe[PIN_BUSY])
    else $error("drive swap left the second pair driven");

  chk_dual_pairs_on: assert property (
    (ctl.owner == OWN_FLOPPY && ctl.live && !ctl.single_mode && !fdc_drive_out[FO_SEL0]
     && !fdc_drive_out[FO_SEL1]) |=> pin_oe[PIN_STROBE] && pin_oe[PIN_ACK])
    else $error("dual-drive mode did not drive both select lines");

  chk_floppy_idle_float: assert property (
    (ctl.owner == OWN_FLOPPY && !state_q.owner_ctrl[OWN_FDC_ACT])
    |=> pin_oe == '0)
    else $error("inactive floppy controller still drives pins");

  chk_host_idle_float: assert property (
    (ctl.owner == OWN_HOST && !state_q.owner_ctrl[OWN_PP_ACT])
    |=> pin_oe == '0)
    else $error("inactive legacy port still drives pins");

  chk_port_en_gate: assert property (
    (ctl.owner == OWN_HOST && !state_q.disable_r[DIS_PORT_EN])
    |=> pin_oe == '0)
    else $error("cleared port-enable bit left legacy pins driven");

  chk_host_pin_pass: assert property (
    (ctl.owner == OWN_HOST && ctl.live)
    |=> pin_oe == $past(lp_oe) && pin_o == $past(lp_o))
    else $error("live legacy port does not own the pins");

  chk_host_read_pass: assert property (
    ctl.owner == OWN_HOST
    |=> lp_data_rd == $past(lp_data_rd_in) && lp_ctrl_rd == $past(lp_ctrl_rd_in))
    else $error("legacy register reads not passed through");

  chk_data_shadow_hold: assert property (
    (!lp_data_wr_stb && ctl.owner != OWN_HOST)
    |=> lp_data_rd == $past(state_q.data_shadow))
    else $error("legacy data read lost the last written value");

  chk_mcu_pin_follow: assert property (
    ctl.owner == OWN_MCU
    |=> pin_o == $past(mcu_o))
    else $error("microcontroller pin values not passed through");

  chk_mcu_data_drive: assert property (
    (ctl.owner == OWN_MCU && ctl.live && mcu_data_out_en)
    |=> (pin_oe & MCU_DATA_MASK) == MCU_DATA_MASK)
    else $error("microcontroller data lines not driven on request");

  chk_floppy_open_drain: assert property (
    ctl.owner == OWN_FLOPPY
    |=> pin_o == '0)
    else $error("floppy outputs not open drain");

  cov_mcu_owner: cover property (ctl.owner == OWN_MCU && ctl.live);
  cov_floppy_single: cover property (ctl.owner == OWN_FLOPPY && ctl.live && ctl.single_mode);
  cov_host_owner: cover property (ctl.owner == OWN_HOST && ctl.live);
  cov_owner_switch: cover property ((ctl.owner == OWN_HOST) ##1 (ctl.owner == OWN_FLOPPY));
endmodule
`default_nettype wire

// >>> pin_mux_pkg.sv
// Operation
// - Host select 0 gives the pins to the microcontroller as a two-way port.
// - Host select 1 with mode bits 01 or 10 puts the floppy drive interface there.
// - Host select 1 with mode bits 00 or 11 gives the pins to the legacy port.
// - Under legacy ownership the legacy port's power-down state decides the pins.
// - Under floppy ownership the floppy controller's power-down state decides the pins.
// - Microcontroller outputs always drive, floating only while power-good is low.
// - Without ownership a legacy data read returns the last data written.
// - Without ownership the control read shows strobe, feed, select-in 0 and init 1.
// - Without ownership the status read shows busy, paper, selected 0, ack, error 1.
// - The port-enable bit only matters while the legacy port owns the pins.
// - Floppy mode maps each drive signal to its fixed port pin.
// - Dual-drive drives both motor/select pairs; single-drive drives only one pair.
// - The floppy sub-mode comes from bits 4:3 of the device mode register.
// - Drive swap 0 puts drive 1 on the port pins; 1 puts drive 0 there.
// - An inactive or powered-down owner leaves every pin floating.
package pin_mux_pkg;
  // ===========================================================================
  // Pins
  localparam int unsigned NUM_PINS      = 17;
  localparam int unsigned PIN_STROBE    = 0;
  localparam int unsigned PIN_DATA0     = 1;
  localparam int unsigned PIN_ACK       = 9;
  localparam int unsigned PIN_BUSY      = 10;
  localparam int unsigned PIN_PAPER_END = 11;
  localparam int unsigned PIN_SELECTED  = 12;
  localparam int unsigned PIN_AUTO_FEED = 13;
  localparam int unsigned PIN_ERROR     = 14;
  localparam int unsigned PIN_INIT      = 15;
  localparam int unsigned PIN_SELECT_IN = 16;
  localparam logic [16:0] MCU_OUT_MASK  = 17'h1a001;
  localparam logic [16:0] MCU_DATA_MASK = 17'h001fe;
  // ===========================================================================
  // Floppy signal vectors
  localparam int unsigned FO_COUNT = 10;
  localparam int unsigned FO_SEL0 = 0, FO_SEL1 = 1, FO_MOTOR0 = 2, FO_MOTOR1 = 3;
  localparam int unsigned FO_WRITE_DATA = 4, FO_WRITE_GATE = 5, FO_DENSITY = 6;
  localparam int unsigned FO_HEAD = 7, FO_DIR = 8, FO_STEP = 9;
  localparam int unsigned FI_COUNT = 7;
  // ===========================================================================
  // Registers
  localparam logic [7:0]  REG_DEVICE_MODE_IDX = 8'h25;
  localparam logic [11:0] ADDR_DEVICE_MODE    = {2'h0, REG_DEVICE_MODE_IDX, 2'h0};
  localparam logic [11:0] ADDR_OWNER_CTRL     = 12'h000;
  localparam logic [11:0] ADDR_FLOPPY_MODE    = 12'h004;
  localparam logic [11:0] ADDR_DISABLE        = 12'h008;
  localparam logic [11:0] ADDR_STATUS         = 12'h00c;
  localparam int unsigned MODE_LO = 3, OWN_HOST_SEL = 0, OWN_FDC_ACT = 1, OWN_FDC_PD = 2;
  localparam int unsigned OWN_PP_ACT = 3, OWN_PP_PD = 4, FM_DRIVE_SWAP = 4, DIS_PORT_EN = 7;
  localparam logic [7:0]  DEVICE_MODE_RST = 8'h00;
  localparam logic [7:0]  OWNER_CTRL_RST  = 8'h00;
  localparam logic [7:0]  FLOPPY_MODE_RST = 8'h00;
  localparam logic [7:0]  DISABLE_RST     = 8'h00;
  // ===========================================================================
  // Legacy port readback when disconnected
  localparam logic [7:0] CTRL_DISC_MASK = 8'h0f;
  localparam logic [7:0] CTRL_DISC_VAL  = 8'h04;
  localparam logic [7:0] STAT_DISC_MASK = 8'hf8;
  localparam logic [7:0] STAT_DISC_VAL  = 8'h48;
  typedef enum logic [2:0] {
    OWN_MCU    = 3'h1,
    OWN_FLOPPY = 3'h2,
    OWN_HOST   = 3'h4
  } owner_t;
endpackage

// >>> testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench import pin_mux_pkg::*;;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, power_good_pin;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [NUM_PINS-1:0] pin_i, pin_o, pin_oe, pin_sampled, mcu_o, lp_o, lp_oe;
  logic mcu_data_out_en, lp_data_wr_stb, drive_en;
  logic [7:0] lp_data_wr, lp_data_rd_in, lp_ctrl_rd_in, lp_status_rd_in, drive_val;
  logic [7:0] lp_data_rd, lp_ctrl_rd, lp_status_rd;
  logic [FO_COUNT-1:0] fdc_drive_out;
  logic [FI_COUNT-1:0] fdc_drive_in;
  int failures, checks, cycles;
  localparam int unsigned FMAP [10] = '{0, 9, 7, 10, 11, 12, 13, 14, 15, 16};

  parallel_port_pin_owner_mux #(.SINGLE_PATTERN(2'h1)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .power_good_pin(power_good_pin), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe),
    .pin_sampled(pin_sampled), .mcu_o(mcu_o), .mcu_data_out_en(mcu_data_out_en), .lp_o(lp_o),
    .lp_oe(lp_oe), .lp_data_wr_stb(lp_data_wr_stb), .lp_data_wr(lp_data_wr),
    .lp_data_rd_in(lp_data_rd_in), .lp_ctrl_rd_in(lp_ctrl_rd_in),
    .lp_status_rd_in(lp_status_rd_in), .lp_data_rd(lp_data_rd), .lp_ctrl_rd(lp_ctrl_rd),
    .lp_status_rd(lp_status_rd), .fdc_drive_out(fdc_drive_out), .fdc_drive_in(fdc_drive_in));

  far_side_model partner (.pin_o(pin_o), .pin_oe(pin_oe), .drive_en(drive_en),
    .drive_val(drive_val), .pin_i(pin_i));

  // ===========================================================================
  // Clock, timeout and shared tasks
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task automatic finish_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // The whole sequence needs well under a thousand cycles; the ceiling leaves ample room.
  always @(posedge pclk) begin
    cycles++;
    if (cycles > 5000) begin
      failures++;
      finish_test();
    end
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, {24'h0, d}, r, e);
  endtask

  task automatic rd(input string name, input logic [11:0] a, input logic [31:0] x,
                    input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(name, x, r);
    chk({name, " error"}, {31'h0, xe}, {31'h0, e});
  endtask

  // Pins follow a register write one edge later; power-good takes two sync flops plus the pin flop, three edges.
  task automatic settle();
    repeat (4) @(posedge pclk);
  endtask

  // ===========================================================================
  // Main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata, power_good_pin, mcu_o, mcu_data_out_en} = '0;
    {lp_o, lp_oe, lp_data_wr_stb, lp_data_wr, drive_en, drive_val} = '0;
    {lp_data_rd_in, lp_ctrl_rd_in, lp_status_rd_in, fdc_drive_out} = '0;
    {failures, checks, cycles} = '0;
    presetn = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd("owner reset", ADDR_OWNER_CTRL, 32'h0, 1'b0);
    rd("unmapped", 12'h010, 32'h0, 1'b1);
    wr(ADDR_DEVICE_MODE, 8'h08);
    mcu_o <= 17'h0a5a5;
    settle();
    chk("mcu unpowered oe", 32'h0, pin_oe);
    power_good_pin <= 1'b1;
    settle();
    chk("mcu oe", MCU_OUT_MASK, pin_oe);
    chk("mcu out", mcu_o & MCU_OUT_MASK, pin_o & pin_oe);
    mcu_data_out_en <= 1'b1;
    settle();
    chk("mcu data oe", MCU_OUT_MASK | MCU_DATA_MASK, pin_oe);
    // Floppy single-drive with the port enable bit left clear.
    drive_en <= 1'b1;
    drive_val <= 8'ha5;
    wr(ADDR_OWNER_CTRL, 8'h03);
    settle();
    chk("single swap0 oe", 17'h1fe00, pin_oe);
    chk("floppy out", 32'h0, pin_o & pin_oe);
    rd("status floppy", ADDR_STATUS, 32'h3a, 1'b0);
    chk("floppy inputs", 7'h65, fdc_drive_in);
    chk("pin sampled", 17'h0014b, pin_sampled);
    wr(ADDR_FLOPPY_MODE, 8'h10);
    settle();
    chk("single swap1 oe", 17'h1f881, pin_oe);
    wr(ADDR_DEVICE_MODE, 8'h10);
    drive_en <= 1'b0;
    settle();
    chk("dual oe", 17'h1fe81, pin_oe);
    rd("device mode", ADDR_DEVICE_MODE, 32'h10, 1'b0);
    for (int i = 0; i < 10; i++) begin
      fdc_drive_out <= ~(10'h1 << i);
      settle();
      chk("floppy route", 17'h1 << FMAP[i], pin_oe);
    end
    fdc_drive_out <= '0;
    wr(ADDR_OWNER_CTRL, 8'h07);
    settle();
    chk("floppy powerdown oe", 32'h0, pin_oe);
    wr(ADDR_OWNER_CTRL, 8'h01);
    settle();
    chk("floppy inactive oe", 32'h0, pin_oe);
    // Legacy readback while the host does not own the pins.
    lp_data_wr <= 8'h96;
    lp_data_wr_stb <= 1'b1;
    lp_ctrl_rd_in <= 8'hff;
    lp_status_rd_in <= 8'h07;
    lp_data_rd_in <= 8'h3c;
    @(posedge pclk);
    lp_data_wr_stb <= 1'b0;
    settle();
    chk("data readback", 8'h96, lp_data_rd);
    chk("ctrl readback", 8'hf4, lp_ctrl_rd);
    chk("status readback", 8'h4f, lp_status_rd);
    // Legacy ownership with both host patterns of the mode bits.
    lp_oe <= 17'h15a5a;
    lp_o <= 17'h0f0f0;
    wr(ADDR_DEVICE_MODE, 8'h18);
    wr(ADDR_DISABLE, 8'h80);
    wr(ADDR_OWNER_CTRL, 8'h09);
    settle();
    chk("host oe", 17'h15a5a, pin_oe);
    chk("host out", 17'h0f0f0 & 17'h15a5a, pin_o & pin_oe);
    chk("host data read", 8'h3c, lp_data_rd);
    chk("host ctrl read", 8'hff, lp_ctrl_rd);
    wr(ADDR_DISABLE, 8'h00);
    settle();
    chk("port disabled oe", 32'h0, pin_oe);
    wr(ADDR_DISABLE, 8'h80);
    wr(ADDR_OWNER_CTRL, 8'h19);
    settle();
    chk("host powerdown oe", 32'h0, pin_oe);
    wr(ADDR_DEVICE_MODE, 8'h00);
    wr(ADDR_OWNER_CTRL, 8'h09);
    settle();
    chk("host mode 00 oe", 17'h15a5a, pin_oe);
    finish_test();
  end
endmodule
`default_nettype wire
